// ==== hw/error_count_gate_timer_regs.vh ====
// Register offsets, field positions, reset values and counts of the error count gate timer.
`ifndef ERROR_COUNT_GATE_TIMER_REGS_VH
`define ERROR_COUNT_GATE_TIMER_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets.
`define ECG_CTRL_OFS 12'h000
`define ECG_ARM_OFS 12'h004
`define ECG_STATUS_OFS 12'h008
`define ECG_ELAPSED_OFS 12'h00C
`define ECG_TARGET_OFS 12'h010

////////////////////////////////////////////////////////////////////////////////
// Control register fields.
`define ECG_CTRL_PULSE_MODE 0
`define ECG_CTRL_GATE_LOW 1
`define ECG_CTRL_ARM_LOW 2
`define ECG_CTRL_PRESCALE 3
`define ECG_CTRL_SEL_LSB 4
`define ECG_CTRL_MULT_LSB 6
`define ECG_CTRL_WIDTH 8
// Gate active low, arm active high, selector 10^3, multiplier both halves on.
`define ECG_CTRL_RESET 8'hC2

////////////////////////////////////////////////////////////////////////////////
// Status register fields.
`define ECG_STAT_ACTIVE 0
`define ECG_STAT_LAMP 1
`define ECG_STAT_CMP 2

////////////////////////////////////////////////////////////////////////////////
// Window lengths in bit clock cycles.
`define ECG_CNT_W 24
`define ECG_BASE_0 24'h0003E8
`define ECG_BASE_1 24'h002710
`define ECG_BASE_2 24'h0186A0
`define ECG_BASE_3 24'h0F4240
`define ECG_MULT_X1 2'h3
`define ECG_MULT_X2 2'h2
`define ECG_MULT_X4 2'h1
`define ECG_MULT_X8 2'h0
`define ECG_PRESCALE_DIV 24'h00000C
`define ECG_TENTH_DIV 24'h00000A

`endif

// ==== hw/bit_comparator.v ====
// Exclusive-OR comparator of two data streams, optionally gated by the high phase of a clock.
`timescale 1ns/1ps

module bit_comparator (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Streams and gating clock
  input wire stream_a,
  input wire stream_b,
  input wire gate_clk,
  // Mode: high selects pulse mode
  input wire pulse_mode,
  // Result
  output reg diff_q
);

  reg diff_d;

  // Without a gating clock the result follows the exclusive-OR at every edge.
  // In pulse mode the result passes only while the gating clock is high, so a
  // steady difference becomes one pulse per clock cycle.
  always @* begin
    if (pulse_mode) begin
      diff_d = (stream_a ^ stream_b) & gate_clk;
    end else begin
      diff_d = stream_a ^ stream_b;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diff_q <= 1'b0;
    end else begin
      diff_q <= diff_d;
    end
  end

endmodule

// ==== hw/error_count_gate_timer.v ====
// Bit error counting helper: comparator plus retriggerable clock-counting gate, APB slave.
//
// Summary of operation
// - Without a comparator clock the output follows the exclusive-OR of both inputs.
// - In pulse mode the result passes only while the comparator clock is high.
// - The window stays active for the selected clock count after arming.
// - Normal mode selects one thousand up to one million cycles.
// - Normal mode needs both multiplier halves on and the plain prescale setting.
// - Extended mode multiplies the selected count by two, four or eight.
// - The divide-by-twelve prescale uses one twelfth of the count.
// - The window starts on a button press or on the arm input.
// - Arming during a window clears it at once and starts a full one.
// - The lamp is steady, flashes in the last tenth, and is off when idle.
// - Window output polarity is selectable; low is the default.
// - Arm input polarity is selectable; high is the default.
`timescale 1ns/1ps
`include "error_count_gate_timer_regs.vh"

module error_count_gate_timer #(
  parameter FLASH_BITS = 21
) (
  // APB clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Comparator
  input wire stream_a,
  input wire stream_b,
  input wire cmp_clk,
  output wire cmp_out,
  // Gate generator
  input wire gate_clk,
  input wire arm_input,
  output reg gate_out,
  output reg lamp_out
);

  ////////////////////////////////////////////////////////////////////////////
  // States of the gate generator.
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_CLEAR = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;

  ////////////////////////////////////////////////////////////////////////////
  // Window length from selector, multiplier setting and prescale jumper.
  function [`ECG_CNT_W-1:0] window_length;
    input [1:0] sel;
    input [1:0] mult;
    input prescale;
    reg [`ECG_CNT_W-1:0] base;
    reg [`ECG_CNT_W-1:0] full;
    reg [`ECG_CNT_W-1:0] part;
    begin
      case (sel)
        2'h0: base = `ECG_BASE_0;
        2'h1: base = `ECG_BASE_1;
        2'h2: base = `ECG_BASE_2;
        default: base = `ECG_BASE_3;
      endcase
      case (mult)
        `ECG_MULT_X1: full = base;
        `ECG_MULT_X2: full = {base[`ECG_CNT_W-2:0], 1'b0};
        `ECG_MULT_X4: full = {base[`ECG_CNT_W-3:0], 2'b00};
        default: full = {base[`ECG_CNT_W-4:0], 3'b000};
      endcase
      part = full / `ECG_PRESCALE_DIV;
      if (prescale) begin
        window_length = part;
      end else begin
        window_length = full;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  reg [`ECG_CTRL_WIDTH-1:0] ctrl_q;
  reg arm_press_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [`ECG_CNT_W-1:0] elapsed_q;
  reg [`ECG_CNT_W-1:0] elapsed_d;
  reg [`ECG_CNT_W-1:0] target_q;
  reg [`ECG_CNT_W-1:0] target_d;
  reg [`ECG_CNT_W-1:0] tenth_q;
  reg [`ECG_CNT_W-1:0] tenth_d;
  reg [FLASH_BITS-1:0] flash_q;
  reg arm_s1_q;
  reg arm_s2_q;
  reg arm_prev_q;
  reg bclk_s1_q;
  reg bclk_s2_q;
  reg bclk_prev_q;

  wire pulse_mode = ctrl_q[`ECG_CTRL_PULSE_MODE];
  wire gate_low = ctrl_q[`ECG_CTRL_GATE_LOW];
  wire arm_low = ctrl_q[`ECG_CTRL_ARM_LOW];
  wire prescale = ctrl_q[`ECG_CTRL_PRESCALE];
  wire [1:0] count_sel = ctrl_q[`ECG_CTRL_SEL_LSB+1:`ECG_CTRL_SEL_LSB];
  wire [1:0] mult_set = ctrl_q[`ECG_CTRL_MULT_LSB+1:`ECG_CTRL_MULT_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // Comparator.
  bit_comparator u_cmp (
    .pclk(pclk),
    .presetn(presetn),
    .stream_a(stream_a),
    .stream_b(stream_b),
    .gate_clk(cmp_clk),
    .pulse_mode(pulse_mode),
    .diff_q(cmp_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Arm input and gate bit clock synchronisers.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_s1_q <= 1'b0;
      arm_s2_q <= 1'b0;
      arm_prev_q <= 1'b0;
      bclk_s1_q <= 1'b0;
      bclk_s2_q <= 1'b0;
      bclk_prev_q <= 1'b0;
    end else begin
      arm_s1_q <= arm_input;
      arm_s2_q <= arm_s1_q;
      arm_prev_q <= arm_s2_q ^ arm_low;
      bclk_s1_q <= gate_clk;
      bclk_s2_q <= bclk_s1_q;
      bclk_prev_q <= bclk_s2_q;
    end
  end

  // Only the inactive-to-active transition arms, so a held input gives one window.
  wire arm_level = arm_s2_q ^ arm_low;
  wire arm_edge = arm_level & ~arm_prev_q;
  wire arm_event = arm_edge | arm_press_q;
  wire bclk_rise = bclk_s2_q & ~bclk_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Gate generator state machine.
  always @* begin
    state_d = state_q;
    elapsed_d = elapsed_q;
    target_d = target_q;
    tenth_d = tenth_q;
    case (state_q)
      ST_IDLE: begin
        elapsed_d = {`ECG_CNT_W{1'b0}};
        // While idle the target follows the selection, so the length register shows the next window.
        target_d = window_length(count_sel, mult_set, prescale);
        tenth_d = window_length(count_sel, mult_set, prescale) / `ECG_TENTH_DIV;
        if (arm_event) begin
          state_d = ST_CLEAR;
        end
      end
      ST_CLEAR: begin
        // The window is inactive for this one cycle before a full new one.
        target_d = window_length(count_sel, mult_set, prescale);
        tenth_d = window_length(count_sel, mult_set, prescale) / `ECG_TENTH_DIV;
        elapsed_d = {`ECG_CNT_W{1'b0}};
        state_d = ST_RUN;
      end
      ST_RUN: begin
        if (arm_event) begin
          elapsed_d = {`ECG_CNT_W{1'b0}};
          state_d = ST_CLEAR;
        end else if (bclk_rise) begin
          if (elapsed_q + 24'h000001 >= target_q) begin
            elapsed_d = {`ECG_CNT_W{1'b0}};
            state_d = ST_IDLE;
          end else begin
            elapsed_d = elapsed_q + 24'h000001;
          end
        end
      end
      default: begin
        elapsed_d = {`ECG_CNT_W{1'b0}};
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      elapsed_q <= {`ECG_CNT_W{1'b0}};
      target_q <= {`ECG_CNT_W{1'b0}};
      tenth_q <= {`ECG_CNT_W{1'b0}};
    end else begin
      state_q <= state_d;
      elapsed_q <= elapsed_d;
      target_q <= target_d;
      tenth_q <= tenth_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Window output and lamp.
  wire active_d = (state_d == ST_RUN);
  wire in_last_tenth = (target_d - elapsed_d) <= tenth_d;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_q <= {FLASH_BITS{1'b0}};
      gate_out <= 1'b0;
      lamp_out <= 1'b0;
    end else begin
      flash_q <= flash_q + 1'b1;
      gate_out <= active_d ^ gate_low;
      if (!active_d) begin
        lamp_out <= 1'b0;
      end else if (in_last_tenth) begin
        lamp_out <= flash_q[FLASH_BITS-1];
      end else begin
        lamp_out <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, error on unmapped offsets.
  wire setup = psel & ~penable;
  wire access = psel & penable & pready;
  wire mapped = (paddr == `ECG_CTRL_OFS) | (paddr == `ECG_ARM_OFS) |
                (paddr == `ECG_STATUS_OFS) | (paddr == `ECG_ELAPSED_OFS) |
                (paddr == `ECG_TARGET_OFS);

  reg [31:0] rdata_d;

  always @* begin
    rdata_d = 32'h00000000;
    case (paddr)
      `ECG_CTRL_OFS: rdata_d = {24'h000000, ctrl_q};
      `ECG_STATUS_OFS: rdata_d = {29'h00000000, cmp_out, lamp_out, state_q == ST_RUN};
      `ECG_ELAPSED_OFS: rdata_d = {8'h00, elapsed_q};
      `ECG_TARGET_OFS: rdata_d = {8'h00, target_q};
      default: rdata_d = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `ECG_CTRL_RESET;
      arm_press_q <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      arm_press_q <= 1'b0;
      if (setup && !pwrite) begin
        prdata <= rdata_d;
      end
      if (access && pwrite) begin
        if (paddr == `ECG_CTRL_OFS) begin
          ctrl_q <= pwdata[`ECG_CTRL_WIDTH-1:0];
        end
        if (paddr == `ECG_ARM_OFS) begin
          arm_press_q <= pwdata[0];
        end
      end
    end
  end

endmodule

// ==== verif/error_count_gate_timer_monitor.sv ====
// Port checks of the gate timer: bus answer and comparator output.
`timescale 1ns/1ps
module ecg_monitor (
  // Clock, reset and bus
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  // Comparator
  input wire stream_a,
  input wire stream_b,
  input wire cmp_clk,
  input wire cmp_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_bad;
    s_setup ##0 (paddr > 12'h010);
  endsequence
  sequence s_good;
    s_setup ##0 (paddr <= 12'h010 && paddr[1:0] == 2'h0);
  endsequence
  a_ready_setup: assert property (s_setup |=> pready) else $error("no ready after setup");
  a_ready_once: assert property (pready |=> !pready) else $error("ready held");
  a_ready_access: assert property (pready |-> psel && penable) else $error("stray ready");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_err_bad: assert property (s_bad |=> pslverr) else $error("unmapped not refused");
  a_err_good: assert property (s_good |=> !pslverr) else $error("mapped refused");
  a_cmp_equal: assert property ($past(presetn) && $past(stream_a == stream_b) |-> !cmp_out)
    else $error("equal streams flagged");
  a_cmp_pass: assert property ($past(presetn) && $past(stream_a ^ stream_b)
    && $past(cmp_clk) |-> cmp_out) else $error("difference lost");
endmodule
bind error_count_gate_timer ecg_monitor u_ecg_monitor (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .stream_a(stream_a), .stream_b(stream_b), .cmp_clk(cmp_clk), .cmp_out(cmp_out));

// ==== verif/ecg_partner.sv ====
// Bit clock source and downstream pulse counter of the gate timer.
`timescale 1ns/1ps
module ecg_partner (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Gate side
  input wire gate_out,
  input wire act_low,
  output reg gate_clk,
  output reg [15:0] cnt
);
  reg [2:0] sync_q;
  reg act_q;
  reg half_q;
  wire act = gate_out ^ act_low;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_clk <= 1'b0;
      half_q <= 1'b0;
      sync_q <= 3'h0;
      act_q <= 1'b0;
      cnt <= 16'h0000;
    end else begin
      half_q <= ~half_q;
      if (half_q) begin
        gate_clk <= ~gate_clk;
      end
      sync_q <= {sync_q[1:0], gate_clk};
      act_q <= act;
      // One confirmation count at window start, then one per bit clock rise.
      cnt <= cnt + {15'h0000, act & ~act_q} + {15'h0000, act & sync_q[1] & ~sync_q[2]};
    end
  end
endmodule

// ==== verif/error_count_gate_timer_tb_top.sv ====
// Self-checking bench of the gate timer.
`timescale 1ns/1ps
module error_count_gate_timer_tb_top;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h00000000;
  reg stream_a = 1'b0;
  reg stream_b = 1'b0;
  reg cmp_clk = 1'b0;
  reg arm_input = 1'b0;
  reg act_low = 1'b1;
  wire [31:0] prdata;
  wire pready, pslverr, cmp_out, gate_clk, gate_out, lamp_out;
  wire [15:0] cnt;
  logic [31:0] rd;
  logic err;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  int flash = 0;
  int c1, i, m, s, p;
  error_count_gate_timer #(.FLASH_BITS(3)) u_error_count_gate_timer (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stream_a(stream_a), .stream_b(stream_b), .cmp_clk(cmp_clk), .cmp_out(cmp_out),
    .gate_clk(gate_clk), .arm_input(arm_input), .gate_out(gate_out), .lamp_out(lamp_out));
  ecg_partner u_ecg_partner (.pclk(pclk), .presetn(presetn), .gate_out(gate_out),
    .act_low(act_low), .gate_clk(gate_clk), .cnt(cnt));
  initial begin
    forever begin
      #20 pclk = ~pclk;
    end
  end
  ////////////////////////////////////////
  task stop_test;
    $display("Counts: %0d compared, %0d failed", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ready, read data and error are taken at the rising edge that samples ready high.
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_gate(input logic lvl);
    do @(negedge pclk); while (gate_out !== lvl);
  endtask
  // Waits a few cycles only: the gate must answer an arming at once.
  task gate_soon(input logic lvl, input string what);
    for (i = 0; i < 10 && gate_out !== lvl; i++) @(negedge pclk);
    chk(what, {31'h0, lvl}, {31'h0, gate_out});
  endtask
  function int base_len(input int k);
    return 1000 * (10 ** k);
  endfunction
  always @(negedge pclk) begin
    if (gate_out === ~act_low && lamp_out === 1'b0) flash++;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  ////////////////////////////////////////
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl reset", 32'h000000C2, rd);
    apb(1'b0, 12'h010, 32'h0);
    chk("target reset", 32'h000003E8, rd);
    chk("gate idle", 32'h1, {31'h0, gate_out});
    for (p = 0; p < 2; p++) begin
      for (s = 0; s < 4; s++) begin
        for (m = 0; m < 4; m++) begin
          apb(1'b1, 12'h000, m * 64 + s * 16 + p * 8 + 2);
          apb(1'b0, 12'h010, 32'h0);
          chk("target", base_len(s) * (8 >> m) / (p ? 12 : 1), rd);
        end
      end
    end
    apb(1'b1, 12'h014, 32'h000000FF);
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl kept", 32'h000000FA, rd);
    $display("Test registers done");
    apb(1'b1, 12'h000, 32'h000000C8);
    act_low <= 1'b0;
    apb(1'b1, 12'h004, 32'h1);
    wait_gate(1'b1);
    chk("lamp steady", 32'h1, {31'h0, lamp_out});
    c1 = cnt;
    flash = 0;
    apb(1'b0, 12'h008, 32'h0);
    chk("status active", 32'h3, rd);
    wait_gate(1'b0);
    chk("window count", 84, cnt - c1);
    chk("flash tail", 32'h1, {31'h0, flash > 0 && flash <= 36});
    chk("lamp off", 32'h0, {31'h0, lamp_out});
    apb(1'b0, 12'h00C, 32'h0);
    chk("elapsed cleared", 32'h0, rd);
    $display("Test window done");
    arm_input <= 1'b1;
    wait_gate(1'b1);
    repeat (100) @(posedge pclk);
    arm_input <= 1'b0;
    repeat (5) @(posedge pclk);
    arm_input <= 1'b1;
    gate_soon(1'b0, "retrigger clear");
    wait_gate(1'b1);
    c1 = cnt;
    wait_gate(1'b0);
    chk("full new window", 84, cnt - c1);
    repeat (50) @(posedge pclk);
    chk("held arm idle", 32'h0, {31'h0, gate_out});
    $display("Test retrigger done");
    apb(1'b1, 12'h000, 32'h000000CA);
    act_low <= 1'b1;
    repeat (2) @(negedge pclk);
    chk("gate idle high", 32'h1, {31'h0, gate_out});
    apb(1'b1, 12'h000, 32'h000000CE);
    arm_input <= 1'b0;
    gate_soon(1'b0, "low arm starts");
    wait_gate(1'b1);
    $display("Test polarity done");
    for (p = 0; p < 2; p++) begin
      apb(1'b1, 12'h000, 32'h000000C2 + p);
      for (s = 0; s < 8; s++) begin
        @(posedge pclk);
        stream_a <= s[0];
        stream_b <= s[1];
        cmp_clk <= s[2];
        @(posedge pclk);
        @(negedge pclk);
        chk("cmp", {31'h0, (s[0] ^ s[1]) & (s[2] | !p)}, {31'h0, cmp_out});
      end
    end
    $display("Test comparator done");
    stop_test();
  end
endmodule
